// >>> i2c_sbi_pkg.sv
// Constants, field layout and types shared by the two-wire serial bus interface.
// Assumes a 25 MHz register clock and APB byte addresses of four times the index.
`default_nettype none
package i2c_sbi_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // Register indices; the APB byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DATA = 10'h241;
  localparam logic [IDX_W-1:0] IDX_OWN_ADDR = 10'h242;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h243;
  localparam logic [IDX_W-1:0] IDX_IDLE = 10'h244;
  localparam logic [IDX_W-1:0] IDX_CTRL1 = 10'h245;
  localparam logic [IDX_W-1:0] IDX_CTRL0 = 10'h246;
  // Status and control_reg_two bit positions
  localparam int POS_MST = 7;
  localparam int POS_TRX = 6;
  localparam int POS_BB = 5;
  localparam int POS_PIN = 4;
  localparam int POS_AL = 3;
  localparam int POS_AAS = 2;
  localparam int POS_AD0 = 1;
  localparam int POS_LRB = 0;
  // control_reg_one, control_reg_zero, idle_mode_control, own_slave_address
  localparam int POS_BC_LSB = 5;
  localparam int POS_ACK = 4;
  localparam int POS_EN = 7;
  localparam int POS_RUN_IDLE = 6;
  localparam int POS_ALS = 0;
  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [2:0] BC_RST = 3'h0;
  localparam logic ACK_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  localparam logic RUN_IDLE_RST = 1'b0;
  localparam logic PIN_RST = 1'b1;
  // Register clock period and master clock half period
  localparam int CLK_NS = 40;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_LOW, M_STOP_HIGH} master_state_type;

  // Bits per word: code 000 stands for a full eight-bit word
  function automatic logic [3:0] word_bits(input logic [2:0] bc);
    word_bits = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction
endpackage
`default_nettype wire

// >>> sbi_sync3.sv
// Three-stage synchroniser for a bus pin sampled on the register clock.
// The output only follows once the second and third stages agree.
`default_nettype none
module sbi_sync3 (
  input wire logic ref_clk_i, // Register clock
  input wire logic reset_i,   // Asynchronous reset, active high
  input wire logic ce_i,      // Clock enable
  input wire logic async_i,   // Pin level from outside the domain
  output logic sync_o         // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      sync_o <= 1'b1;
    end
    else if (ce_i)
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        sync_o <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// >>> sbi_shifter.sv
// Word shifter following the bus clock edges, for master and slave alike.
// Assumes edge and start pulses come from already synchronised levels.
`default_nettype none
module sbi_shifter (
  input wire logic ref_clk_i,        // Register clock
  input wire logic reset_i,          // Asynchronous reset, active high
  input wire logic run_i,            // Engine enable
  input wire logic scl_rise_i,       // Bus clock rose
  input wire logic scl_fall_i,       // Bus clock fell
  input wire logic start_det_i,      // Start condition seen
  input wire logic sda_i,            // Synchronised data line
  input wire logic load_i,           // Load transmit word
  input wire logic [7:0] load_data_i, // Transmit word
  input wire logic [3:0] bits_i,     // Bits per word
  input wire logic ack_en_i,         // Acknowledge mode
  input wire logic trx_i,            // Transmitting
  input wire logic engage_i,         // Taking part in this transfer
  input wire logic ack_allow_i,      // Receiver may acknowledge
  output logic sda_low_o,            // Pull data line low
  output logic [7:0] rx_data_o,      // Received word
  output logic last_bit_o,           // Last bit sampled
  output logic done_o,               // One-cycle pulse: word complete
  output logic arb_lost_o            // One-cycle pulse: line differed from ours
);
  logic [7:0] tx_sh_reg;
  logic [3:0] bit_num_reg;
  logic sampled_reg;
  logic [3:0] total;
  logic in_ack;

  assign total = bits_i + {3'h0, ack_en_i};
  assign in_ack = ack_en_i && (bit_num_reg == bits_i);
  // Receiver acks low, transmitter lets go of the line
  assign sda_low_o = engage_i && (in_ack ? (!trx_i && ack_allow_i)
                                         : (trx_i && !tx_sh_reg[7]));

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_sh_reg <= 8'hFF;
      bit_num_reg <= 4'h0;
      sampled_reg <= 1'b0;
      rx_data_o <= 8'h00;
      last_bit_o <= 1'b0;
      done_o <= 1'b0;
      arb_lost_o <= 1'b0;
    end
    else if (run_i)
    begin
      done_o <= 1'b0;
      arb_lost_o <= 1'b0;
      if (load_i)
        tx_sh_reg <= load_data_i;
      if (start_det_i)
      begin
        bit_num_reg <= 4'h0;
        sampled_reg <= 1'b0;
        rx_data_o <= 8'h00;
      end
      else if (scl_rise_i)
      begin
        sampled_reg <= 1'b1;
        last_bit_o <= sda_i;
        if (!in_ack)
        begin
          rx_data_o <= {rx_data_o[6:0], sda_i};
          if (engage_i && trx_i && tx_sh_reg[7] && !sda_i)
            arb_lost_o <= 1'b1;
        end
      end
      else if (scl_fall_i && sampled_reg)
      begin
        sampled_reg <= 1'b0;
        if (bit_num_reg + 4'h1 >= total)
        begin
          bit_num_reg <= 4'h0;
          done_o <= 1'b1;
        end
        else
        begin
          bit_num_reg <= bit_num_reg + 4'h1;
          if (!in_ack && !load_i)
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> i2c_serial_bus_interface_ctrl.sv
// Two-wire serial bus interface: APB registers, master clock, slave matching.
// Assumes APB from the register clock domain and open-drain bus pins outside.
`default_nettype none
module i2c_serial_bus_interface_ctrl (
  input wire logic ref_clk_i,                        // Register clock, 25 MHz
  input wire logic reset_i,                          // Asynchronous reset
  input wire logic ce_i,                             // Clock enable, freezes all
  input wire logic second_idle_mode_i,               // Chip in second idle mode
  input wire logic psel_i,                           // APB select
  input wire logic penable_i,                        // APB enable
  input wire logic pwrite_i,                         // APB direction
  input wire logic [i2c_sbi_pkg::ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i,                  // APB write data
  output logic [31:0] prdata_o,                      // APB read data
  output logic pready_o,                             // APB ready
  output logic pslverr_o,                            // APB error
  input wire logic scl_i,                            // Clock line level
  output logic scl_o,                                // Clock line drive value
  output logic scl_oe_n_o,                           // Clock line enable, low drives
  input wire logic sda_i,                            // Data line level
  output logic sda_o,                                // Data line drive value
  output logic sda_oe_n_o                            // Data line enable, low drives
);
  import i2c_sbi_pkg::*;

  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic run;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [IDX_W-1:0] idx;
  logic mapped;
  logic acc_done;
  logic wr;
  logic rd;
  logic wr_data;
  logic rd_data;
  logic wr_cr2;
  logic [7:0] rd_mux;
  logic [7:0] own_addr_reg;
  logic run_in_idle_reg;
  logic [2:0] bc_reg;
  logic ack_reg;
  logic en_reg;
  logic mst_reg;
  logic trx_reg;
  logic bb_reg;
  logic pin_reg;
  logic al_reg;
  logic aas_reg;
  logic ad0_reg;
  logic lrb_reg;
  logic slave_sel_reg;
  logic first_word_reg;
  logic start_req_reg;
  logic stop_req_reg;
  master_state_type m_state_reg;
  logic [7:0] m_cnt_reg;
  logic half_up;
  logic m_scl_low;
  logic m_sda_low;
  logic sh_sda_low;
  logic [7:0] rx_data;
  logic last_bit;
  logic sh_done;
  logic sh_arb;
  logic arb_lost;
  logic hit;
  logic engage;
  logic ack_allow;
  logic word_ev;
  logic start_cmd;
  logic stop_cmd;

  sbi_sync3 u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(scl_i),
    .sync_o(scl_s)
  );

  sbi_sync3 u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(sda_i),
    .sync_o(sda_s)
  );

  // Registers stay reachable in idle; only the bus engine stops
  assign run = ce_i && !(second_idle_mode_i && !run_in_idle_reg);

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else if (run)
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = run && scl_s && !scl_d_reg;
  assign scl_fall = run && !scl_s && scl_d_reg;
  assign start_det = run && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = run && scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // APB decode
  assign idx = paddr_i[ADDR_W-1:2];
  assign mapped = (paddr_i[1:0] == 2'b00) && (idx == IDX_DATA || idx == IDX_OWN_ADDR ||
                  idx == IDX_STATUS || idx == IDX_IDLE || idx == IDX_CTRL1 || idx == IDX_CTRL0);
  assign acc_done = ce_i && psel_i && penable_i && pready_o;
  assign wr = acc_done && pwrite_i && !pslverr_o;
  assign rd = acc_done && !pwrite_i && !pslverr_o;
  assign wr_data = wr && (idx == IDX_DATA);
  assign rd_data = rd && (idx == IDX_DATA);
  assign wr_cr2 = wr && (idx == IDX_STATUS);
  assign start_cmd = wr_cr2 && !bb_reg && (pwdata_i[7:4] == 4'hF);
  assign stop_cmd = wr_cr2 && bb_reg && (pwdata_i[7:4] == 4'hD);

  always_comb
  begin
    rd_mux = 8'h00;
    case (idx)
      IDX_DATA: rd_mux = rx_data;
      IDX_OWN_ADDR: rd_mux = own_addr_reg;
      IDX_STATUS: rd_mux = {mst_reg, trx_reg, bb_reg, pin_reg && en_reg,
                            al_reg, aas_reg, ad0_reg, lrb_reg};
      IDX_IDLE: rd_mux = {1'b0, run_in_idle_reg, 6'h00};
      IDX_CTRL1: rd_mux = {bc_reg, ack_reg, 4'h0};
      IDX_CTRL0: rd_mux = {en_reg, 7'h00};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle, so every access has no wait state
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pready_o <= psel_i && !penable_i;
      if (psel_i && !penable_i)
      begin
        prdata_o <= {24'h00_0000, rd_mux};
        pslverr_o <= !mapped;
      end
    end
  end

  // Plain software settings
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      own_addr_reg <= OWN_ADDR_RST;
      run_in_idle_reg <= RUN_IDLE_RST;
      ack_reg <= ACK_RST;
      en_reg <= EN_RST;
    end
    else if (ce_i)
    begin
      if (wr && idx == IDX_OWN_ADDR)
        own_addr_reg <= pwdata_i[7:0];
      if (wr && idx == IDX_IDLE)
        run_in_idle_reg <= pwdata_i[POS_RUN_IDLE];
      if (wr && idx == IDX_CTRL1)
        ack_reg <= pwdata_i[POS_ACK];
      if (wr && idx == IDX_CTRL0)
        en_reg <= pwdata_i[POS_EN];
    end
  end

  // Bit count: a start wins over a software write in the same cycle
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      bc_reg <= BC_RST;
    else if (ce_i)
    begin
      if (start_det)
        bc_reg <= 3'h0;
      else if (wr && idx == IDX_CTRL1)
        bc_reg <= pwdata_i[POS_BC_LSB+2:POS_BC_LSB];
    end
  end

  // Address match: own address in bits 7..1, or an all-zero general call
  assign hit = (rx_data[7:1] == own_addr_reg[7:1]) || (rx_data == 8'h00);
  assign engage = en_reg && (mst_reg || slave_sel_reg || first_word_reg);
  assign ack_allow = mst_reg || !first_word_reg || own_addr_reg[POS_ALS] || hit;
  assign word_ev = sh_done && en_reg && (mst_reg || slave_sel_reg ||
                   (first_word_reg && (own_addr_reg[POS_ALS] || hit)));
  assign arb_lost = sh_arb && mst_reg;

  // Bus state, role and address detection
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bb_reg <= 1'b0;
      mst_reg <= 1'b0;
      trx_reg <= 1'b0;
      slave_sel_reg <= 1'b0;
      first_word_reg <= 1'b0;
      aas_reg <= 1'b0;
      ad0_reg <= 1'b0;
      lrb_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_det)
        bb_reg <= 1'b1;
      else if (stop_det)
        bb_reg <= 1'b0;
      if (sh_done)
        lrb_reg <= last_bit;
      if (start_det)
      begin
        first_word_reg <= 1'b1;
        aas_reg <= 1'b0;
        ad0_reg <= 1'b0;
      end
      else if (sh_done)
        first_word_reg <= 1'b0;
      if (stop_det || arb_lost)
      begin
        mst_reg <= 1'b0;
        trx_reg <= 1'b0;
        slave_sel_reg <= 1'b0;
      end
      else if (sh_done && first_word_reg && !mst_reg && word_ev)
      begin
        slave_sel_reg <= 1'b1;
        aas_reg <= !own_addr_reg[POS_ALS];
        ad0_reg <= (rx_data == 8'h00);
        trx_reg <= rx_data[0];
      end
      else if (sh_done && first_word_reg && mst_reg && !last_bit)
        trx_reg <= !rx_data[0];
      else if (wr_cr2)
      begin
        mst_reg <= pwdata_i[POS_MST];
        trx_reg <= pwdata_i[POS_TRX];
      end
    end
  end

  // Pending-inverse and arbitration flags; hardware events win over software
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_reg <= PIN_RST;
      al_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (word_ev)
        pin_reg <= 1'b0;
      else if (wr_data || rd_data || (wr_cr2 && pwdata_i[POS_PIN]))
        pin_reg <= 1'b1;
      if (arb_lost)
        al_reg <= 1'b1;
      else if (wr_data || rd_data || wr_cr2)
        al_reg <= 1'b0;
    end
  end

  // Master clock generator; high phase counts only while the line is really high
  assign half_up = (m_cnt_reg >= 8'(SCL_HALF_CYC - 1));

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      m_state_reg <= M_IDLE;
      m_cnt_reg <= 8'h00;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_cmd)
        start_req_reg <= 1'b1;
      if (stop_cmd)
        stop_req_reg <= 1'b1;
      if (run)
      begin
        m_cnt_reg <= half_up ? 8'h00 : m_cnt_reg + 8'h01;
        case (m_state_reg)
          M_IDLE:
          begin
            m_cnt_reg <= 8'h00;
            stop_req_reg <= 1'b0;
            if (start_req_reg && !bb_reg)
            begin
              start_req_reg <= 1'b0;
              m_state_reg <= M_START;
            end
          end
          M_START:
            if (half_up)
              m_state_reg <= M_LOW;
          M_LOW:
            if (arb_lost || !mst_reg)
              m_state_reg <= M_IDLE;
            else if (!pin_reg)
              m_cnt_reg <= 8'h00;
            else if (half_up)
              m_state_reg <= stop_req_reg ? M_STOP_LOW : M_HIGH;
          M_HIGH:
            if (arb_lost || !mst_reg)
              m_state_reg <= M_IDLE;
            else if (!scl_s)
              m_cnt_reg <= 8'h00;
            else if (half_up)
              m_state_reg <= M_LOW;
          M_STOP_LOW:
            if (half_up)
              m_state_reg <= M_STOP_HIGH;
          M_STOP_HIGH:
            if (half_up)
              m_state_reg <= M_IDLE;
          default:
            m_state_reg <= M_IDLE;
        endcase
      end
    end
  end

  assign m_scl_low = (m_state_reg == M_LOW) || (m_state_reg == M_STOP_LOW);
  assign m_sda_low = (m_state_reg == M_START) || (m_state_reg == M_STOP_LOW) ||
                     (m_state_reg == M_STOP_HIGH);

  sbi_shifter u_shifter (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .scl_rise_i(scl_rise),
    .scl_fall_i(scl_fall),
    .start_det_i(start_det),
    .sda_i(sda_s),
    .load_i(wr_data),
    .load_data_i(pwdata_i[7:0]),
    .bits_i(word_bits(bc_reg)),
    .ack_en_i(ack_reg),
    .trx_i(trx_reg && (mst_reg || slave_sel_reg)),
    .engage_i(engage),
    .ack_allow_i(ack_allow),
    .sda_low_o(sh_sda_low),
    .rx_data_o(rx_data),
    .last_bit_o(last_bit),
    .done_o(sh_done),
    .arb_lost_o(sh_arb)
  );

  // Pins: the clock is held low while a word waits for software
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= !(m_scl_low ||
                      (en_reg && bb_reg && !pin_reg && (mst_reg || slave_sel_reg)));
      // A master's shifter drives only in bit phases, so start and stop own the data line
      sda_oe_n_o <= !(en_reg && (m_sda_low || (sh_sda_low && (!mst_reg ||
                      m_state_reg == M_LOW || m_state_reg == M_HIGH))));
    end
  end
endmodule
`default_nettype wire

// >>> i2c_sbi_checker.sv
// Port checker for the two-wire serial bus block.
// Assumes the bind below attaches it to every instance of the block.
`default_nettype none
module i2c_sbi_checker (
  input wire logic ref_clk_i, // Register clock
  input wire logic reset_i, // Asynchronous reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic [i2c_sbi_pkg::ADDR_W-1:0] paddr_i, // APB address
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic scl_o, // Clock drive value
  input wire logic scl_oe_n_o, // Clock enable, low drives
  input wire logic sda_o, // Data drive value
  input wire logic sda_oe_n_o // Data enable, low drives
);
  timeunit 1ns;
  timeprecision 1ns;
  logic setup;
  logic bad;
  assign setup = psel_i && !penable_i;
  // Mapped words are 0x904 to 0x918, all aligned
  assign bad = paddr_i[1:0] != 2'h0 || paddr_i < 12'h904 || paddr_i > 12'h918;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  chk_ready_after_setup: assert property (setup |=> pready_o)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_no_stray_ready: assert property (!setup |=> !pready_o)
    else $error("ready without setup");
  chk_err_unmapped: assert property (setup && bad |=> pslverr_o)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (setup && !bad |=> !pslverr_o)
    else $error("error on mapped access");
  chk_byte_wide: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line driven high");
  chk_scl_low_min: assert property ($fell(scl_oe_n_o) |=> !scl_oe_n_o [*8])
    else $error("clock low half too short");
  chk_scl_high_min: assert property ($rose(scl_oe_n_o) |=> scl_oe_n_o [*8])
    else $error("clock high half too short");
  cover property (setup ##1 pslverr_o);
  cover property ($fell(scl_oe_n_o));
  cover property ($fell(sda_oe_n_o) && scl_oe_n_o);
endmodule
bind i2c_serial_bus_interface_ctrl i2c_sbi_checker chk_i (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_o(scl_o),
  .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire

// >>> sbi_bus_peer.sv
// Behavioural slave receiver on the two-wire bus.
// Assumes resolved line levels with pull-ups; it never drives the clock.
`default_nettype none
module sbi_bus_peer (
  input wire logic scl_i, // Resolved clock line
  input wire logic sda_i, // Resolved data line
  input wire logic ack_en_i, // Acknowledge the address word
  output logic sda_rel_o, // 1 releases the data line
  output logic [7:0] got_o, // Bits sampled, newest at bit 0
  output logic [7:0] rises_o // Clock rises seen
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitn = 0;
  initial sda_rel_o = 1'b1;
  initial got_o = 8'h00;
  initial rises_o = 8'h00;
  // Start condition restarts the word
  always @(negedge sda_i) if (scl_i === 1'b1) bitn = 0;
  always @(posedge scl_i)
  begin
    rises_o = rises_o + 8'h01;
    got_o = {got_o[6:0], sda_i};
    bitn++;
  end
  // Ack held from the fall after the eighth bit to the next fall
  always @(negedge scl_i) sda_rel_o = !(ack_en_i && bitn == 8);
endmodule
`default_nettype wire

// >>> test_i2c_serial_bus_interface_ctrl.sv
// Self-checking bench for the two-wire serial bus block.
// Assumes the package, the design, the peer model and the checker are compiled first.
`default_nettype none
module test_i2c_serial_bus_interface_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic second_idle_mode = 1'b0;
  logic peer_ack = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, peer_rel;
  logic [7:0] rdat, got, rises, r0;
  logic rerr;
  wire logic scl;
  wire logic sda;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Wired-AND with pull-ups; drive values are always low
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & peer_rel;
  i2c_serial_bus_interface_ctrl i2c_serial_bus_interface_ctrl_i (.ref_clk_i(ref_clk),
    .reset_i(reset), .ce_i(1'b1), .second_idle_mode_i(second_idle_mode), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n));
  sbi_bus_peer sbi_bus_peer_i (.scl_i(scl), .sda_i(sda), .ack_en_i(peer_ack),
    .sda_rel_o(peer_rel), .got_o(got), .rises_o(rises));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Each access writes or reads a whole register, never read-modify-write
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(nm, rdat, exp);
  endtask
  // Polls status; each read takes a few cycles, far under a word time
  task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
    apb(1'b0, 12'h90C, 8'h00);
    while ((rdat & mask) !== val)
      apb(1'b0, 12'h90C, 8'h00);
  endtask
  task automatic t_reset();
    rd("own address", 12'h908, 8'h00);
    rd("idle control", 12'h910, 8'h00);
    rd("status disabled", 12'h90C, 8'h00);
    apb(1'b0, 12'h900, 8'h00);
    check("unmapped error", rerr, 8'h01);
    apb(1'b1, 12'h905, 8'hFF);
    check("unaligned error", rerr, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_regs();
    apb(1'b1, 12'h908, 8'hA5);
    rd("own address", 12'h908, 8'hA5);
    apb(1'b1, 12'h910, 8'h40);
    rd("run in idle", 12'h910, 8'h40);
    apb(1'b1, 12'h918, 8'h80);
    rd("status enabled", 12'h90C, 8'h10);
    // Writing the status address loads control two instead
    apb(1'b1, 12'h90C, 8'h40);
    rd("transmit via status", 12'h90C, 8'h50);
    apb(1'b1, 12'h90C, 8'h00);
    rd("transmit cleared", 12'h90C, 8'h10);
    $display("test registers done");
  endtask
  task automatic t_master();
    logic [7:0] e1;
    e1 = {7'h26, 1'b0}; // Low seven address bits, then the peer's ack
    // Bit count of three is set before start, which must clear it
    apb(1'b1, 12'h914, 8'h70);
    apb(1'b1, 12'h904, 8'hA6);
    r0 = rises;
    apb(1'b1, 12'h90C, 8'hF0);
    wait_stat(8'h10, 8'h00);
    check("address clocks", rises - r0, 8'h09);
    check("address bits", got, e1);
    check("status after word", rdat, 8'hE0);
    apb(1'b1, 12'h914, 8'h60);
    r0 = rises;
    apb(1'b1, 12'h904, 8'h5A);
    rd("pending after write", 12'h90C, 8'hF0 & 8'hF0);
    wait_stat(8'h10, 8'h00);
    check("short word clocks", rises - r0, 8'h03);
    check("short word bits", got, {e1[4:0], 3'b010});
    apb(1'b1, 12'h90C, 8'hD0);
    wait_stat(8'h20, 8'h00);
    check("free after stop", rdat & 8'hA0, 8'h00);
    $display("test master done");
  endtask
  task automatic t_idle();
    apb(1'b1, 12'h910, 8'h00);
    apb(1'b1, 12'h904, 8'hA6);
    second_idle_mode <= 1'b1;
    r0 = rises;
    apb(1'b1, 12'h90C, 8'hF0);
    repeat (300) @(posedge ref_clk);
    check("clocks in idle", rises - r0, 8'h00);
    rd("frozen in idle", 12'h90C, 8'hD0);
    second_idle_mode <= 1'b0;
    wait_stat(8'h20, 8'h20);
    check("busy after idle", rdat & 8'hA0, 8'hA0);
    $display("test idle done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_master();
    t_idle();
    close_out();
  end
endmodule
`default_nettype wire
